// ===== tb/tb.sv
// self-checking bench for the trigger and exposure sequencer
`timescale 1ns/1ps
module tb;
    logic CORE_CLK = 1'b0;
    logic RST = 1'b1;
    logic WB_CYC = 1'b0, WB_STB = 1'b0, WB_WE = 1'b0;
    logic [7:0] WB_ADR = 8'h00;
    logic [31:0] WB_DAT_W = 32'h0000_0000, WB_DAT_R, rd;
    logic WB_ACK, PIN, RDD, XB, TRIG_WAIT, EXPO_ACTIVE, FRAME_ACTIVE, XFER_ACTIVE, WINDOW_LOCK, EVT_VALID, EVT_READY;
    logic [1:0] GPIO_OUT;
    logic [3:0] SET_INDEX, EVT_CODE;
    logic level = 1'b0, pol_low = 1'b0, eq = 1'b0;
    int failures = 0, comparisons = 0, ex, st, dl, sb, fr, xa, gx;
    int ev0 [16];
    always #5 CORE_CLK = ~CORE_CLK;
    tes_sequencer u_tes_sequencer (.CORE_CLK(CORE_CLK), .RST(RST), .WB_CYC(WB_CYC), .WB_STB(WB_STB),
        .WB_WE(WB_WE), .WB_ADR(WB_ADR), .WB_SEL(4'hF), .WB_DAT_W(WB_DAT_W), .WB_DAT_R(WB_DAT_R),
        .WB_ACK(WB_ACK), .EXT_TRIG(PIN), .SENSOR_RDOUT_DONE(RDD), .XFER_BUSY(XB), .TRIG_WAIT(TRIG_WAIT),
        .EXPO_ACTIVE(EXPO_ACTIVE), .FRAME_ACTIVE(FRAME_ACTIVE), .XFER_ACTIVE(XFER_ACTIVE), .GPIO_OUT(GPIO_OUT),
        .SET_INDEX(SET_INDEX), .WINDOW_LOCK(WINDOW_LOCK), .EVT_VALID(EVT_VALID), .EVT_CODE(EVT_CODE),
        .EVT_READY(EVT_READY));
    tes_partner u_tes_partner (.clk(CORE_CLK), .level(level), .pol_low(pol_low), .wait_i(TRIG_WAIT),
        .expo(EXPO_ACTIVE), .frame(FRAME_ACTIVE), .ev_valid(EVT_VALID), .ev_code(EVT_CODE), .pin(PIN),
        .rd_done(RDD), .busy(XB), .ev_ready(EVT_READY));
    // cycle counters; delay phase is neither waiting nor in a frame
    always @(posedge CORE_CLK) begin
        ex += (EXPO_ACTIVE === 1'b1);
        st += (EXPO_ACTIVE === 1'b1 && !eq);
        dl += (TRIG_WAIT === 1'b0 && FRAME_ACTIVE === 1'b0);
        sb += (GPIO_OUT[0] === 1'b1);
        fr += (FRAME_ACTIVE === 1'b1);
        xa += (XFER_ACTIVE === 1'b1);
        gx += (GPIO_OUT[1] === 1'b1);
        eq = EXPO_ACTIVE;
    end
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task give_verdict;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : give_verdict
    // one classic cycle; the slave answer time is never assumed
    task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge CORE_CLK);
        WB_CYC <= 1'b1;
        WB_STB <= 1'b1;
        WB_WE <= we;
        WB_ADR <= a;
        WB_DAT_W <= d;
        do begin
            @(posedge CORE_CLK);
            n++;
        end while (WB_ACK !== 1'b1 && n < 100);
        rd = WB_DAT_R;
        WB_CYC <= 1'b0;
        WB_STB <= 1'b0;
        @(posedge CORE_CLK);
        if (n >= 100) failures++;
    endtask : wb
    task clr;
        {ex, st, dl, sb, fr, xa, gx} = '0;
        ev0 = u_tes_partner.ev_cnt;
    endtask : clr
    task settle;
        int n;
        n = 0;
        repeat (4) @(posedge CORE_CLK);
        while (!(TRIG_WAIT === 1'b1 && FRAME_ACTIVE === 1'b0 && XFER_ACTIVE === 1'b0) && n < 2000) begin
            @(posedge CORE_CLK);
            n++;
        end
        repeat (12) @(posedge CORE_CLK);
        if (n >= 2000) failures++;
    endtask : settle
    function automatic int evd(input int c);
        return u_tes_partner.ev_cnt[c] - ev0[c];
    endfunction : evd
    task t_edge;
        wb(1, tes_pkg::SEQ_CNT_OFS, 2);
        wb(1, tes_pkg::EXPO_TIME_OFS, 5);
        wb(1, tes_pkg::TRIG_DELAY_OFS, 2);
        wb(1, tes_pkg::STROBE_DELAY_OFS, 2);
        wb(1, tes_pkg::STROBE_WIDTH_OFS, 3);
        wb(1, tes_pkg::GPIO_CFG_OFS, 32'h0000_0020);
        wb(1, tes_pkg::CTRL_OFS, 32'h0000_0028);
        clr;
        wb(1, tes_pkg::SW_TRIG_OFS, 1);
        // second trigger lands during exposure and must be dropped
        wb(1, tes_pkg::SW_TRIG_OFS, 1);
        settle;
        check("expo len", ex, 5);
        check("starts", st, 1);
        check("delay", dl, 2);
        check("strobe len", sb, 3);
        check("gpio expo len", gx, 5);
        check("frame len", fr, 13);
        foreach (ev0[c]) if (c inside {1, 2, 3, 6, 7, 8, 9}) check("event", evd(c), 1);
        check("set index", {SET_INDEX, 3'h0, WINDOW_LOCK}, 8'h11);
    endtask : t_edge
    task t_level;
        wb(1, tes_pkg::FILTER_OFS, 0);
        wb(1, tes_pkg::TRIG_DELAY_OFS, 0);
        pol_low <= 1'b1;
        wb(1, tes_pkg::CTRL_OFS, 32'h0000_0011);
        clr;
        level <= 1'b1;
        repeat (20) @(posedge CORE_CLK);
        level <= 1'b0;
        settle;
        check("level len", ex, 20);
        check("level starts", st, 1);
    endtask : t_level
    task t_burst;
        wb(1, tes_pkg::BURST_CNT_OFS, 3);
        wb(1, tes_pkg::CTRL_OFS, 32'h0000_000E);
        clr;
        wb(1, tes_pkg::SW_TRIG_OFS, 1);
        settle;
        check("burst frames", st, 3);
        check("xfer begin events", evd(4), 3);
        check("xfer done events", evd(5), 3);
        check("xfer len", xa, 12);
    endtask : t_burst
    task t_glitch;
        pol_low <= 1'b0;
        wb(1, tes_pkg::FILTER_OFS, tes_pkg::FILTER_RST);
        wb(1, tes_pkg::CTRL_OFS, 0);
        clr;
        level <= 1'b1;
        repeat (2) @(posedge CORE_CLK);
        level <= 1'b0;
        settle;
        check("glitch", st, 0);
        level <= 1'b1;
        repeat (12) @(posedge CORE_CLK);
        level <= 1'b0;
        settle;
        check("long pulse starts", st, 1);
        check("long pulse len", ex, 5);
    endtask : t_glitch
    task t_gpio;
        wb(1, tes_pkg::GPIO_CFG_OFS, 32'h0000_0151);
        wb(1, 8'h3C, 32'hFFFF_FFFF);
        wb(0, 8'h3C, 0);
        check("unmapped read", rd, 32'h0000_0000);
        check("gpio static wait", GPIO_OUT, 2'b11);
        wb(1, tes_pkg::GPIO_CFG_OFS, 32'h0000_0201);
        wb(0, tes_pkg::GPIO_CFG_OFS, 0);
        check("gpio cfg read", rd, 32'h0000_0201);
        repeat (3) @(posedge CORE_CLK);
        check("gpio low", GPIO_OUT, 2'b00);
    endtask : t_gpio
    initial begin
        #1_000_000;
        failures++;
        give_verdict;
    end
    initial begin
        repeat (10) @(posedge CORE_CLK);
        RST <= 1'b0;
        t_edge;
        t_level;
        t_burst;
        t_glitch;
        t_gpio;
        give_verdict;
    end
endmodule : tb

// ===== tb/tes_partner.sv
// far-side model: trigger source, sensor readout, host link and event sink
`timescale 1ns/1ps
module tes_partner (
    input wire logic clk,
    input wire logic level,
    input wire logic pol_low,
    input wire logic wait_i,
    input wire logic expo,
    input wire logic frame,
    input wire logic ev_valid,
    input wire logic [3:0] ev_code,
    output logic pin,
    output logic rd_done,
    output logic busy,
    output logic ev_ready
);
    logic on = 1'b0;
    int ro = 0;
    int xf = 0;
    int tick = 0;
    int ev_cnt [16];
    assign pin = on ^ pol_low;
    // sink stalls one cycle in four so events sit pending a while
    assign ev_ready = tick % 4 != 3;
    initial rd_done = 1'b0;
    initial busy = 1'b0;
    always @(posedge clk) begin
        tick <= tick + 1;
        if (level && !on && wait_i) begin
            on <= 1'b1;
        end else if (!level) begin
            on <= 1'b0;
        end
        ro <= (frame && !expo && !rd_done) ? ro + 1 : 0;
        rd_done <= ro == 6;
        xf <= rd_done ? 4 : (xf > 0 ? xf - 1 : 0);
        busy <= rd_done || xf > 1;
        if (ev_valid && ev_ready) begin
            ev_cnt[ev_code] <= ev_cnt[ev_code] + 1;
        end
    end
endmodule : tes_partner

// ===== verilog/tes_pkg.sv
// constants, states and register map of the trigger and exposure sequencer
//------------------------------------------------------------------------------
// What this block does
// - edge mode: one exposure per accepted trigger, length set by exposure time
// - level mode with pin source: exposure lasts as long as the trigger stays active
// - burst mode: one trigger exposes and transfers a programmed series of frames
// - trigger source is the external pin or a software command, chosen by config
// - trigger pin polarity is active-high or active-low per setting
// - programmable delay between accepted trigger and exposure start
// - trigger pin is filtered against glitches and chatter before use
// - trigger-wait asserted while a trigger can be taken; taken trigger exposes after the programmed delay
// - each event is reported to the host as one event packet; a repeat while it is still pending merges
// - events for trigger accepted, trigger rejected and start of waiting
// - events for start and end of frame data transfer
// - events for exposure start and end and strobe timer start and end
// - each general output drives a chosen source, one being the strobe pulse
// - static-level source drives the level written in configuration
// - exposure-active output high from exposure start to exposure end
// - frame-active output high from exposure start until sensor readout done
// - transfer-active output high while frame data goes over the host bus
// - sequential mode steps stored setting sets per frame; window size locked
//------------------------------------------------------------------------------
package tes_pkg;
    typedef enum logic [2:0] {
        TES_WAIT, TES_DELAY, TES_EXPOSE, TES_READOUT
    } tes_state_t;

    // register byte addresses
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] TRIG_DELAY_OFS = 8'h04;
    localparam logic [7:0] EXPO_TIME_OFS = 8'h08;
    localparam logic [7:0] BURST_CNT_OFS = 8'h0C;
    localparam logic [7:0] STROBE_DELAY_OFS = 8'h10;
    localparam logic [7:0] STROBE_WIDTH_OFS = 8'h14;
    localparam logic [7:0] GPIO_CFG_OFS = 8'h18;
    localparam logic [7:0] SW_TRIG_OFS = 8'h1C;
    localparam logic [7:0] FILTER_OFS = 8'h20;
    localparam logic [7:0] SEQ_CNT_OFS = 8'h24;
    localparam logic [7:0] STATUS_OFS = 8'h28;

    // control fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_SRC_SW_BIT = 3;
    localparam int CTRL_POL_LOW_BIT = 4;
    localparam int CTRL_SEQ_EN_BIT = 5;
    localparam logic [2:0] EDGE_CAPTURE_MODE = 3'h0;
    localparam logic [2:0] LEVEL_CAPTURE_MODE = 3'h1;
    localparam logic [2:0] BURST_CAPTURE_MODE = 3'h6;

    // general output sources
    localparam logic [2:0] SRC_STROBE = 3'h0;
    localparam logic [2:0] SRC_STATIC = 3'h1;
    localparam logic [2:0] SRC_EXPO = 3'h2;
    localparam logic [2:0] SRC_CAPTURE = 3'h3;
    localparam logic [2:0] SRC_XFER = 3'h4;
    localparam logic [2:0] SRC_WAIT = 3'h5;

    // event codes are index plus one
    localparam int EV_ACCEPT = 0;
    localparam int EV_REJECT = 1;
    localparam int EV_READY = 2;
    localparam int EV_XFER_BEGIN = 3;
    localparam int EV_XFER_DONE = 4;
    localparam int EV_EXPO_BEGIN = 5;
    localparam int EV_EXPO_DONE = 6;
    localparam int EV_STROBE_BEGIN = 7;
    localparam int EV_STROBE_DONE = 8;
    localparam int EV_NUM = 9;

    // reset values: 10 us exposure, filters at 4 cycles
    localparam logic [31:0] EXPO_TIME_RST = 32'h0000_03E8;
    localparam logic [31:0] FILTER_RST = 32'h0004_0004;
    localparam logic [15:0] BURST_CNT_RST = 16'h0001;
    localparam logic [3:0] SEQ_CNT_RST = 4'h1;
endpackage : tes_pkg

// ===== verilog/tes_sequencer.sv
// trigger conditioning, exposure sequencing, strobe timer, events and wishbone registers
//
// The placing of the registers and the Wishbone register port were decided locally.
`timescale 1ns/1ps
module tes_sequencer (
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic WB_CYC,
    input wire logic WB_STB,
    input wire logic WB_WE,
    input wire logic [7:0] WB_ADR,
    input wire logic [3:0] WB_SEL,
    input wire logic [31:0] WB_DAT_W,
    output logic [31:0] WB_DAT_R,
    output logic WB_ACK,
    input wire logic EXT_TRIG,
    input wire logic SENSOR_RDOUT_DONE,
    input wire logic XFER_BUSY,
    output logic TRIG_WAIT,
    output logic EXPO_ACTIVE,
    output logic FRAME_ACTIVE,
    output logic XFER_ACTIVE,
    output logic [1:0] GPIO_OUT,
    output logic [3:0] SET_INDEX,
    output logic WINDOW_LOCK,
    output logic EVT_VALID,
    output logic [3:0] EVT_CODE,
    input wire logic EVT_READY
);
    //--------------------------------------------------------------------------
    // state
    //--------------------------------------------------------------------------
    typedef struct packed {
        tes_pkg::tes_state_t state;
        logic [31:0] cnt;
        logic [15:0] frames_left;
        logic [3:0] set_idx;
        logic filt;
        logic filt_q;
        logic [15:0] glitch_cnt;
        logic [15:0] hold_cnt;
        logic [1:0] st_phase;
        logic [31:0] st_cnt;
        logic xfer_q;
        logic [tes_pkg::EV_NUM-1:0] pend;
        logic evt_valid;
        logic [3:0] evt_code;
        logic [1:0] gpio;
        logic ack;
        logic [31:0] rdata;
        logic [5:0] ctrl;
        logic [31:0] trig_delay;
        logic [31:0] expo_time;
        logic [15:0] burst_cnt;
        logic [31:0] st_delay;
        logic [31:0] st_width;
        logic [9:0] gpio_cfg;
        logic [31:0] filt_cfg;
        logic [3:0] seq_cnt;
        logic sw_pulse;
        logic started;
    } tes_regs_t;

    tes_regs_t st_reg;
    tes_regs_t st_next;

    function automatic logic [31:0] tes_wmask(input logic [31:0] old, input logic [31:0] dat,
                                             input logic [3:0] sel);
        logic [31:0] m;
        m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
        return (old & ~m) | (dat & m);
    endfunction : tes_wmask

    logic [2:0] mode;
    logic level_mode;
    logic burst_mode;
    logic raw_trig;
    logic trig;
    logic wr;
    logic [31:0] wv;
    logic [31:0] rd;
    logic [tes_pkg::EV_NUM-1:0] ev;
    logic [tes_pkg::EV_NUM-1:0] pend_all;
    logic start_expo;
    logic gsel0;
    logic gsel1;

    function automatic logic tes_gsrc(input logic [2:0] sel, input logic lvl, input tes_regs_t s);
        unique case (sel)
            tes_pkg::SRC_STROBE: return s.st_phase == 2'h2;
            tes_pkg::SRC_STATIC: return lvl;
            tes_pkg::SRC_EXPO: return s.state == tes_pkg::TES_EXPOSE;
            tes_pkg::SRC_CAPTURE: return s.state inside {tes_pkg::TES_EXPOSE, tes_pkg::TES_READOUT};
            tes_pkg::SRC_XFER: return s.xfer_q;
            tes_pkg::SRC_WAIT: return s.state == tes_pkg::TES_WAIT;
            default: return 1'b0;
        endcase
    endfunction : tes_gsrc

    //--------------------------------------------------------------------------
    // next state
    //--------------------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        ev = '0;
        start_expo = 1'b0;
        mode = st_reg.ctrl[tes_pkg::CTRL_MODE_LSB +: 3];
        level_mode = mode == tes_pkg::LEVEL_CAPTURE_MODE && !st_reg.ctrl[tes_pkg::CTRL_SRC_SW_BIT];
        burst_mode = mode == tes_pkg::BURST_CAPTURE_MODE;

        // wishbone slave, one wait state, unmapped reads give zero
        wr = WB_CYC && WB_STB && WB_WE && st_reg.ack;
        wv = '0;
        st_next.ack = WB_CYC && WB_STB && !st_reg.ack;
        st_next.sw_pulse = 1'b0;
        if (wr) begin
            unique case (WB_ADR)
                tes_pkg::CTRL_OFS: begin
                    wv = tes_wmask({26'h0, st_reg.ctrl}, WB_DAT_W, WB_SEL);
                    st_next.ctrl = wv[5:0];
                end
                tes_pkg::TRIG_DELAY_OFS: st_next.trig_delay = tes_wmask(st_reg.trig_delay, WB_DAT_W, WB_SEL);
                tes_pkg::EXPO_TIME_OFS: st_next.expo_time = tes_wmask(st_reg.expo_time, WB_DAT_W, WB_SEL);
                tes_pkg::BURST_CNT_OFS: begin
                    wv = tes_wmask({16'h0, st_reg.burst_cnt}, WB_DAT_W, WB_SEL);
                    st_next.burst_cnt = wv[15:0];
                end
                tes_pkg::STROBE_DELAY_OFS: st_next.st_delay = tes_wmask(st_reg.st_delay, WB_DAT_W, WB_SEL);
                tes_pkg::STROBE_WIDTH_OFS: st_next.st_width = tes_wmask(st_reg.st_width, WB_DAT_W, WB_SEL);
                tes_pkg::GPIO_CFG_OFS: begin
                    wv = tes_wmask({22'h0, st_reg.gpio_cfg}, WB_DAT_W, WB_SEL);
                    st_next.gpio_cfg = wv[9:0];
                end
                tes_pkg::SW_TRIG_OFS: st_next.sw_pulse = WB_SEL[0] && WB_DAT_W[0];
                tes_pkg::FILTER_OFS: st_next.filt_cfg = tes_wmask(st_reg.filt_cfg, WB_DAT_W, WB_SEL);
                tes_pkg::SEQ_CNT_OFS: begin
                    wv = tes_wmask({28'h0, st_reg.seq_cnt}, WB_DAT_W, WB_SEL);
                    st_next.seq_cnt = wv[3:0];
                end
                default: ;
            endcase
        end
        unique case (WB_ADR)
            tes_pkg::CTRL_OFS: rd = {26'h0, st_reg.ctrl};
            tes_pkg::TRIG_DELAY_OFS: rd = st_reg.trig_delay;
            tes_pkg::EXPO_TIME_OFS: rd = st_reg.expo_time;
            tes_pkg::BURST_CNT_OFS: rd = {16'h0, st_reg.burst_cnt};
            tes_pkg::STROBE_DELAY_OFS: rd = st_reg.st_delay;
            tes_pkg::STROBE_WIDTH_OFS: rd = st_reg.st_width;
            tes_pkg::GPIO_CFG_OFS: rd = {22'h0, st_reg.gpio_cfg};
            tes_pkg::FILTER_OFS: rd = st_reg.filt_cfg;
            tes_pkg::SEQ_CNT_OFS: rd = {28'h0, st_reg.seq_cnt};
            tes_pkg::STATUS_OFS: rd = {st_reg.frames_left, 4'h0, st_reg.set_idx, 3'h0, st_reg.xfer_q,
                                       st_reg.filt, 1'b0, 2'(st_reg.state)};
            default: rd = 32'h0000_0000;
        endcase
        st_next.rdata = (WB_CYC && WB_STB && !st_reg.ack) ? rd : 32'h0000_0000;

        // trigger pin filter: glitch needs a stable run, chatter holds after a change
        raw_trig = EXT_TRIG ^ st_reg.ctrl[tes_pkg::CTRL_POL_LOW_BIT];
        st_next.filt_q = st_reg.filt;
        if (st_reg.hold_cnt != 16'h0000) begin
            st_next.hold_cnt = st_reg.hold_cnt - 16'h0001;
        end
        if (raw_trig == st_reg.filt) begin
            st_next.glitch_cnt = 16'h0000;
        end else if (st_reg.glitch_cnt >= st_reg.filt_cfg[15:0] && st_reg.hold_cnt == 16'h0000) begin
            st_next.filt = raw_trig;
            st_next.glitch_cnt = 16'h0000;
            st_next.hold_cnt = st_reg.filt_cfg[31:16];
        end else if (st_reg.glitch_cnt != 16'hFFFF) begin
            st_next.glitch_cnt = st_reg.glitch_cnt + 16'h0001;
        end
        trig = st_reg.ctrl[tes_pkg::CTRL_SRC_SW_BIT] ? st_reg.sw_pulse
                                                     : (st_reg.filt && !st_reg.filt_q);

        // sequencing
        if (!st_reg.started) begin
            st_next.started = 1'b1;
            ev[tes_pkg::EV_READY] = 1'b1;
        end
        if (trig && st_reg.state != tes_pkg::TES_WAIT) begin
            ev[tes_pkg::EV_REJECT] = 1'b1;
        end
        unique case (st_reg.state)
            tes_pkg::TES_WAIT: begin
                if (trig) begin
                    ev[tes_pkg::EV_ACCEPT] = 1'b1;
                    st_next.frames_left = (burst_mode && st_reg.burst_cnt != 16'h0000) ?
                                          st_reg.burst_cnt - 16'h0001 : 16'h0000;
                    if (st_reg.trig_delay == 32'h0000_0000) begin
                        start_expo = 1'b1;
                    end else begin
                        st_next.state = tes_pkg::TES_DELAY;
                        st_next.cnt = st_reg.trig_delay;
                    end
                end
            end
            tes_pkg::TES_DELAY: begin
                if (st_reg.cnt <= 32'h0000_0001) begin
                    start_expo = 1'b1;
                end else begin
                    st_next.cnt = st_reg.cnt - 32'h0000_0001;
                end
            end
            tes_pkg::TES_EXPOSE: begin
                if (level_mode ? !st_reg.filt : st_reg.cnt <= 32'h0000_0001) begin
                    ev[tes_pkg::EV_EXPO_DONE] = 1'b1;
                    st_next.state = tes_pkg::TES_READOUT;
                end else begin
                    st_next.cnt = st_reg.cnt - 32'h0000_0001;
                end
            end
            tes_pkg::TES_READOUT: begin
                if (SENSOR_RDOUT_DONE) begin
                    if (st_reg.ctrl[tes_pkg::CTRL_SEQ_EN_BIT]) begin
                        st_next.set_idx = (st_reg.set_idx + 4'h1 >= st_reg.seq_cnt) ? 4'h0
                                          : st_reg.set_idx + 4'h1;
                    end
                    if (st_reg.frames_left != 16'h0000) begin
                        st_next.frames_left = st_reg.frames_left - 16'h0001;
                        start_expo = 1'b1;
                    end else begin
                        st_next.state = tes_pkg::TES_WAIT;
                        ev[tes_pkg::EV_READY] = 1'b1;
                    end
                end
            end
        endcase
        if (start_expo) begin
            st_next.state = tes_pkg::TES_EXPOSE;
            st_next.cnt = st_reg.expo_time;
            ev[tes_pkg::EV_EXPO_BEGIN] = 1'b1;
        end

        // strobe timer runs from exposure start: delay, then pulse
        if (start_expo && st_reg.st_width != 32'h0000_0000) begin
            if (st_reg.st_delay == 32'h0000_0000) begin
                st_next.st_phase = 2'h2;
                st_next.st_cnt = st_reg.st_width;
                ev[tes_pkg::EV_STROBE_BEGIN] = 1'b1;
            end else begin
                st_next.st_phase = 2'h1;
                st_next.st_cnt = st_reg.st_delay;
            end
        end else if (st_reg.st_phase == 2'h1) begin
            if (st_reg.st_cnt <= 32'h0000_0001) begin
                st_next.st_phase = 2'h2;
                st_next.st_cnt = st_reg.st_width;
                ev[tes_pkg::EV_STROBE_BEGIN] = 1'b1;
            end else begin
                st_next.st_cnt = st_reg.st_cnt - 32'h0000_0001;
            end
        end else if (st_reg.st_phase == 2'h2) begin
            if (st_reg.st_cnt <= 32'h0000_0001) begin
                st_next.st_phase = 2'h0;
                ev[tes_pkg::EV_STROBE_DONE] = 1'b1;
            end else begin
                st_next.st_cnt = st_reg.st_cnt - 32'h0000_0001;
            end
        end

        // host transfer tracking
        st_next.xfer_q = XFER_BUSY;
        ev[tes_pkg::EV_XFER_BEGIN] = XFER_BUSY && !st_reg.xfer_q;
        ev[tes_pkg::EV_XFER_DONE] = !XFER_BUSY && st_reg.xfer_q;

        // one packet per pending bit; a new event on the bit being sent stays pending for its own packet,
        // while a new event on a bit still waiting to be sent merges with it
        pend_all = st_reg.pend | ev;
        st_next.pend = pend_all;
        if (!st_reg.evt_valid || EVT_READY) begin
            st_next.evt_valid = 1'b0;
            for (int i = tes_pkg::EV_NUM - 1; i >= 0; i--) begin
                if (st_reg.pend[i]) begin
                    st_next.evt_valid = 1'b1;
                    st_next.evt_code = 4'(i + 1);
                end
            end
            for (int i = 0; i < tes_pkg::EV_NUM; i++) begin
                if (st_reg.pend[i] && st_next.evt_code == 4'(i + 1) && st_next.evt_valid) begin
                    st_next.pend[i] = ev[i]; // set wins over clear
                end
            end
        end

        gsel0 = tes_gsrc(st_reg.gpio_cfg[2:0], st_reg.gpio_cfg[8], st_reg);
        gsel1 = tes_gsrc(st_reg.gpio_cfg[6:4], st_reg.gpio_cfg[9], st_reg);
        st_next.gpio = {gsel1, gsel0};
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            st_reg <= '{state: tes_pkg::TES_WAIT, expo_time: tes_pkg::EXPO_TIME_RST,
                        filt_cfg: tes_pkg::FILTER_RST, burst_cnt: tes_pkg::BURST_CNT_RST,
                        seq_cnt: tes_pkg::SEQ_CNT_RST, default: '0};
        end else begin
            st_reg <= st_next;
        end
    end

    //--------------------------------------------------------------------------
    // outputs
    //--------------------------------------------------------------------------
    assign WB_ACK = st_reg.ack;
    assign WB_DAT_R = st_reg.rdata;
    assign TRIG_WAIT = st_reg.state == tes_pkg::TES_WAIT;
    assign EXPO_ACTIVE = st_reg.state == tes_pkg::TES_EXPOSE;
    assign FRAME_ACTIVE = st_reg.state inside {tes_pkg::TES_EXPOSE, tes_pkg::TES_READOUT};
    assign XFER_ACTIVE = st_reg.xfer_q;
    assign GPIO_OUT = st_reg.gpio;
    assign SET_INDEX = st_reg.set_idx;
    assign WINDOW_LOCK = st_reg.ctrl[tes_pkg::CTRL_SEQ_EN_BIT];
    assign EVT_VALID = st_reg.evt_valid;
    assign EVT_CODE = st_reg.evt_code;

    //--------------------------------------------------------------------------
    // assertions
    //--------------------------------------------------------------------------
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);

    logic [31:0] expo_len;
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            expo_len <= 32'h0000_0000;
        end else begin
            expo_len <= (st_next.state == tes_pkg::TES_EXPOSE && !start_expo) ? expo_len + 32'h0000_0001
                                                                              : 32'h0000_0000;
        end
    end

    sequence s_take_nodelay;
        TRIG_WAIT && trig && st_reg.trig_delay == 32'h0000_0000;
    endsequence
    sequence s_take_delay2;
        TRIG_WAIT && trig && st_reg.trig_delay == 32'h0000_0002 && !wr;
    endsequence

    wait_start_a: assert property (s_take_nodelay |=> EXPO_ACTIVE && FRAME_ACTIVE)
        else $error("trigger in wait did not start exposure");
    delay_two_a: assert property (s_take_delay2 |=> !EXPO_ACTIVE ##1 !EXPO_ACTIVE ##1 EXPO_ACTIVE)
        else $error("trigger delay of two cycles not kept");
    edge_length_a: assert property (EXPO_ACTIVE && !level_mode && st_next.state != tes_pkg::TES_EXPOSE
        |-> expo_len + 32'h0000_0001 == ((st_reg.expo_time == 0) ? 32'h0000_0001 : st_reg.expo_time))
        else $error("edge exposure length differs from setting");
    level_end_a: assert property (EXPO_ACTIVE && level_mode && !st_reg.filt |=> !EXPO_ACTIVE ##0 FRAME_ACTIVE)
        else $error("level exposure outlived the trigger");
    burst_next_a: assert property (st_reg.state == tes_pkg::TES_READOUT && SENSOR_RDOUT_DONE
        && st_reg.frames_left != 16'h0000 |=> EXPO_ACTIVE && !TRIG_WAIT)
        else $error("burst frame not started without trigger");
    reject_evt_a: assert property (trig && !TRIG_WAIT |=> st_reg.pend[tes_pkg::EV_REJECT])
        else $error("refused trigger raised no rejected event");
    accept_evt_a: assert property (trig && TRIG_WAIT |=> st_reg.pend[tes_pkg::EV_ACCEPT] && !TRIG_WAIT)
        else $error("accepted trigger raised no event");
    filter_run_a: assert property ($changed(st_reg.filt) |-> $past(st_reg.glitch_cnt) >= $past(st_reg.filt_cfg[15:0])
        && $past(st_reg.hold_cnt) == 16'h0000)
        else $error("filtered trigger changed without a stable run");
    static_out_a: assert property (st_reg.gpio_cfg[2:0] == tes_pkg::SRC_STATIC && !wr
        |=> GPIO_OUT[0] == $past(st_reg.gpio_cfg[8]))
        else $error("static output level not driven");
    xfer_begin_a: assert property ($rose(XFER_ACTIVE) |-> st_reg.pend[tes_pkg::EV_XFER_BEGIN]
        || (st_reg.evt_valid && st_reg.evt_code == 4'(tes_pkg::EV_XFER_BEGIN + 1)))
        else $error("transfer start raised no event");
endmodule : tes_sequencer
